// file: core/drc_consts.svh
// constants for the dram access and refresh controller
`ifndef DRC_CONSTS_SVH
`define DRC_CONSTS_SVH
`define DRC_OFF_CTRL 32'h0000_0000
`define DRC_OFF_MAP0 32'h0000_0010
`define DRC_OFF_STAT 32'h0000_0020
`define DRC_CTRL_SC_BIT 31
`define DRC_CTRL_W16_LSB 16
`define DRC_CTRL_PG_LSB 20
`define DRC_CTRL_RATE_LSB 0
`define DRC_RATE_W 9
`define DRC_RATE_RST 9'h1ff
`define DRC_MAP_VALID_BIT 31
`define DRC_MAP_WIN 8'h50
`define DRC_VIDEO_DRAM_HI 6'h18
`define DRC_CLK_NS 8
`define DRC_NORMAL_CYC 3'h4
`define DRC_PAGE_CYC 3'h2
`define DRC_RAS_RISE 3'h3
`define DRC_REF_CYC 3'h4
`endif

// file: core/drc_ctrl.sv
// dram access controller with mapping, refresh and apb registers
`timescale 1ns/10ps
`include "drc_consts.svh"
//////////////////////////////////////////////////////////////////////
// Contract
// [R1] page sequence stays inside 1-Kbyte boundary
// [R2] bank width selectable 32 or 16
// [R3] 32-bit write column strobe patterns
// [R4] 16-bit banks use upper lanes, two accesses
// [R5] 16-bit word read high half first
// [R6] sub-word 16-bit reads single access
// [R7] 16-bit word write high half first
// [R8] 16-bit byte replicated, half on upper
// [R9] 16-bit write column strobe patterns
// [R10] window 50xxxxxx remapped, dma never
// [R11] match virtual base, substitute physical base
// [R12] lowest numbered matching entry wins
// [R13] no match raises mapping-miss exception
// [R14] normal cycle four clocks, no wait
// [R15] row strobe released third edge
// [R16] page mode two-cycle following accesses; pg bits are stored only, every access is a full four-clock cycle
// [R17] static column keeps column strobes low; sc bit is stored only, column strobes are released in every access
// [R18] periodic refresh, zero rate disables
// [R19] one row per bank, in idle
// [R20] panic refresh of remaining banks wins
// [R21] 60-63xxxxxx video transfer, bus driven
// [R22] software clears page bit for 16-bit video
// [R23] reset rate 1ff, map entries uninitialised
module drc_ctrl
   import drc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // processor request
   input wire logic req_valid,
   input wire logic [31:0] req_addr,
   input wire logic req_write,
   input wire logic [1:0] req_size,
   input wire logic [1:0] req_bank,
   input wire logic req_seq,
   input wire logic req_dma,
   input wire logic req_instr,
   input wire logic req_super,
   input wire logic [31:0] req_wdata,
   output logic req_done,
   output logic [31:0] req_rdata,
   output logic map_miss,
   output logic [1:0] miss_kind,
   // dram pins
   output logic [23:1] mem_addr,
   output logic [3:0] row_strobes_n,
   output logic [3:0] column_strobes,
   output logic write_en_n,
   output logic transfer_output_enable,
   output logic [31:0] instr_data_out,
   output logic instr_data_oe,
   input wire logic [31:0] instr_data_in
);
   //////////////////////////////////////////////////////////////////////
   // registers
   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [31:0] map_ff [4];
   logic [31:0] nxt_map [4];
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready;
   logic pslverr_ff, nxt_pslverr;
   logic [31:0] din_s1_ff, din_s2_ff;
   logic [31:0] rdbuf_ff, nxt_rdbuf;
   drc_state_t st_ff, nxt_st;
   logic [2:0] cyc_ff, nxt_cyc;
   logic half2_ff, nxt_half2;
   logic open_ff, nxt_open;
   logic [23:1] addr_ff, nxt_addr;
   logic [3:0] ras_ff, nxt_ras;
   logic [3:0] cas_ff, nxt_cas;
   logic we_ff, nxt_we;
   logic toe_ff, nxt_toe;
   logic [31:0] dout_ff, nxt_dout;
   logic doe_ff, nxt_doe;
   logic done_ff, nxt_done;
   logic [31:0] rdata_ff, nxt_rdata;
   logic miss_ff, nxt_miss;
   logic [1:0] mk_ff, nxt_mk;
   logic [8:0] rcnt_ff, nxt_rcnt;
   logic [3:0] rpend_ff, nxt_rpend;
   logic [1:0] rbank_ff, nxt_rbank;
   logic [1:0] bank_ff, nxt_bank;
   logic w16_ff, nxt_w16;
   logic [31:0] wdat_ff, nxt_wdat;
   logic [1:0] size_ff, nxt_size;
   logic wr_ff, nxt_wr;
   logic a0_ff, nxt_a0;

   logic apb_acc;
   logic [8:0] rate;
   logic sc;
   logic [3:0] w16, pg;
   assign apb_acc = psel & penable & ~pready_ff;
   assign rate = ctrl_ff[`DRC_CTRL_RATE_LSB +: `DRC_RATE_W];
   // page and static column bits stored only, every access is a full cycle
   assign sc = ctrl_ff[`DRC_CTRL_SC_BIT]; // [R17]
   assign w16 = ctrl_ff[`DRC_CTRL_W16_LSB +: 4]; // [R2]
   assign pg = ctrl_ff[`DRC_CTRL_PG_LSB +: 4]; // [R16]

   //////////////////////////////////////////////////////////////////////
   // apb slave
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_map = map_ff;
      nxt_prdata = 32'h0000_0000;
      nxt_pready = apb_acc;
      nxt_pslverr = 1'b0;
      if (apb_acc) begin
         if (paddr == `DRC_OFF_CTRL) begin
            nxt_prdata = ctrl_ff;
            if (pwrite) nxt_ctrl = pwdata & 32'h80ff_01ff;
         end else if (paddr[31:4] == `DRC_OFF_MAP0 >> 4 && paddr[1:0] == 2'h0) begin
            nxt_prdata = map_ff[paddr[3:2]];
            if (pwrite) nxt_map[paddr[3:2]] = pwdata & 32'h80ff_00ff;
         end else if (paddr == `DRC_OFF_STAT) begin
            nxt_prdata = {19'h0, rcnt_ff, rpend_ff};
         end else begin
            nxt_pslverr = 1'b1;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // address mapping
   logic map_hit;
   logic [7:0] map_phys;
   logic in_win, in_vid;
   always_comb begin
      map_hit = 1'b0;
      map_phys = 8'h00;
      for (int i = 3; i >= 0; i--) begin
         // lower index overrides later [R12]
         if (map_ff[i][`DRC_MAP_VALID_BIT] && map_ff[i][23:16] == req_addr[23:16]) begin
            map_hit = 1'b1;
            map_phys = map_ff[i][7:0]; // [R11]
         end
      end
   end
   assign in_win = req_addr[31:24] == `DRC_MAP_WIN && !req_dma; // [R10]
   assign in_vid = req_addr[31:26] == `DRC_VIDEO_DRAM_HI; // [R21]

   // write column strobes, low active
   function automatic logic [3:0] wr_cas(input logic wide16, input logic [1:0] sz,
                                         input logic [1:0] a);
      logic [3:0] c;
      c = 4'h0;
      if (wide16) begin
         if (sz == DRC_SZ_BYTE) c = a[0] ? 4'hb : 4'h7; // [R9]
         else c = 4'h3; // [R9]
      end else if (sz == DRC_SZ_BYTE) begin
         c = ~(4'h8 >> a); // [R3]
      end else if (sz == DRC_SZ_HALF) begin
         c = a[1] ? 4'hc : 4'h3; // [R3]
      end
      return c;
   endfunction

   //////////////////////////////////////////////////////////////////////
   // access and refresh sequencer
   logic start, ref_go, panic;
   logic [23:1] eff_addr;
   logic [31:0] lane_data;
   assign panic = rcnt_ff == 9'h000 && rpend_ff != 4'h0 && rate != 9'h000; // [R20]
   assign eff_addr = in_win ? {map_phys, req_addr[15:1]} : req_addr[23:1];
   always_comb begin
      lane_data = req_wdata;
      if (w16[req_bank]) begin
         if (req_size == DRC_SZ_BYTE) lane_data = {2{req_wdata[7:0]}} << 16; // [R8]
         else lane_data = {req_wdata[31:16] & 16'h0 | req_wdata[15:0], 16'h0}; // [R8]
         if (req_size == DRC_SZ_WORD) lane_data = {req_wdata[31:16], 16'h0}; // [R7]
      end
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_cyc = cyc_ff + 3'h1;
      nxt_half2 = half2_ff;
      nxt_open = open_ff;
      nxt_addr = addr_ff;
      nxt_ras = ras_ff;
      nxt_cas = cas_ff;
      nxt_we = we_ff;
      nxt_toe = toe_ff;
      nxt_dout = dout_ff;
      nxt_doe = doe_ff;
      nxt_done = 1'b0;
      nxt_rdata = rdata_ff;
      nxt_rdbuf = rdbuf_ff;
      nxt_miss = 1'b0;
      nxt_mk = mk_ff;
      nxt_rbank = rbank_ff;
      nxt_bank = bank_ff;
      nxt_w16 = w16_ff;
      nxt_wdat = wdat_ff;
      nxt_size = size_ff;
      nxt_wr = wr_ff;
      nxt_a0 = a0_ff;
      // refresh interval counter [R18]
      nxt_rcnt = rcnt_ff;
      nxt_rpend = rpend_ff;
      if (rate == 9'h000) begin
         nxt_rpend = 4'h0;
         nxt_rcnt = 9'h000;
      end else if (rcnt_ff == 9'h000) begin
         nxt_rcnt = rate;
         if (!panic) nxt_rpend = 4'hf; // [R19]
      end else begin
         nxt_rcnt = rcnt_ff - 9'h001;
      end
      start = req_valid && !done_ff;
      ref_go = rpend_ff != 4'h0 && (panic || !start); // [R19] [R20]
      case (st_ff)
         DRC_IDLE: begin
            nxt_ras = 4'hf;
            nxt_cas = 4'hf;
            nxt_we = 1'b1;
            nxt_toe = 1'b1;
            nxt_doe = 1'b0;
            nxt_cyc = 3'h1;
            nxt_open = 1'b0;
            if (ref_go) begin
               nxt_rbank = rpend_ff[0] ? 2'd0 : rpend_ff[1] ? 2'd1 : rpend_ff[2] ? 2'd2 : 2'd3;
               nxt_cas = 4'h0; // column before row
               nxt_st = DRC_REF;
            end else if (start && in_win && !map_hit) begin
               nxt_miss = 1'b1; // [R13]
               nxt_mk = {req_super, ~req_instr};
               nxt_done = 1'b1;
            end else if (start) begin
               nxt_bank = req_bank;
               nxt_w16 = w16[req_bank];
               nxt_size = req_size;
               nxt_wr = req_write;
               nxt_wdat = req_wdata;
               nxt_addr = eff_addr; // [R1] own row per access, no page run
               nxt_a0 = req_addr[0];
               nxt_half2 = 1'b0;
               nxt_ras = ~(4'h1 << req_bank);
               nxt_we = ~req_write;
               nxt_dout = lane_data; // [R4]
               nxt_doe = req_write | in_vid; // [R21]
               nxt_toe = in_vid ? 1'b0 : req_write;
               nxt_st = in_vid ? DRC_VID : DRC_NORM;
            end
         end
         DRC_NORM, DRC_VID: begin
            // second half: precharge cycle, then row strobe again
            if (cyc_ff == 3'h0) nxt_ras = ~(4'h1 << bank_ff);
            if (cyc_ff == 3'h1) begin
               nxt_cas = wr_ff ? wr_cas(w16_ff, size_ff, {addr_ff[1], a0_ff}) : 4'h0;
               if (st_ff == DRC_VID) nxt_toe = 1'b1;
               else nxt_toe = wr_ff;
            end
            if (cyc_ff == `DRC_RAS_RISE - 3'h1) begin
               nxt_ras = 4'hf; // [R15]
               nxt_cas = 4'hf;
               nxt_toe = 1'b1;
               nxt_doe = st_ff == DRC_VID;
               nxt_rdbuf = instr_data_in;
            end
            if (cyc_ff == `DRC_NORMAL_CYC - 3'h1) begin
               nxt_doe = 1'b0; // [R14]
               nxt_st = DRC_IDLE;
               if (w16_ff && size_ff == DRC_SZ_WORD) begin
                  nxt_half2 = 1'b1;
                  nxt_addr = addr_ff + 23'h1; // [R5]
                  nxt_dout = {wdat_ff[15:0], 16'h0}; // [R7]
                  nxt_doe = wr_ff;
                  nxt_toe = wr_ff;
                  nxt_cyc = 3'h0;
                  nxt_st = DRC_NORM;
                  nxt_open = 1'b0;
                  nxt_size = DRC_SZ_HALF;
                  nxt_rdata = {rdbuf_ff[31:16], 16'h0};
               end else begin
                  nxt_done = 1'b1;
                  nxt_rdata = half2_ff ? {rdata_ff[31:16], rdbuf_ff[31:16]} : rdbuf_ff;
               end
            end
         end
         DRC_REF: begin
            if (cyc_ff == 3'h1) nxt_ras = ~(4'h1 << rbank_ff);
            if (cyc_ff == `DRC_RAS_RISE) begin
               nxt_ras = 4'hf;
               nxt_cas = 4'hf;
               nxt_rpend = nxt_rpend & ~(4'h1 << rbank_ff);
            end
            if (cyc_ff == `DRC_REF_CYC - 3'h1) nxt_st = DRC_IDLE;
         end
         default: nxt_st = DRC_IDLE;
      endcase
   end

   //////////////////////////////////////////////////////////////////////
   // flip-flops
   always_ff @(posedge sys_clk) begin
      map_ff <= nxt_map; // [R23] mapping entries have no reset
      din_s1_ff <= instr_data_in;
      din_s2_ff <= din_s1_ff;
      if (reset) begin
         ctrl_ff <= {23'h0, `DRC_RATE_RST}; // [R23]
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         st_ff <= DRC_IDLE;
         cyc_ff <= 3'h0;
         half2_ff <= 1'b0;
         open_ff <= 1'b0;
         addr_ff <= 23'h0;
         ras_ff <= 4'hf;
         cas_ff <= 4'hf;
         we_ff <= 1'b1;
         toe_ff <= 1'b1;
         dout_ff <= 32'h0000_0000;
         doe_ff <= 1'b0;
         done_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rdbuf_ff <= 32'h0000_0000;
         miss_ff <= 1'b0;
         mk_ff <= 2'h0;
         rcnt_ff <= 9'h000;
         rpend_ff <= 4'h0;
         rbank_ff <= 2'h0;
         bank_ff <= 2'h0;
         w16_ff <= 1'b0;
         wdat_ff <= 32'h0000_0000;
         size_ff <= 2'h0;
         wr_ff <= 1'b0;
         a0_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         st_ff <= nxt_st;
         cyc_ff <= nxt_cyc;
         half2_ff <= nxt_half2;
         open_ff <= nxt_open;
         addr_ff <= nxt_addr;
         ras_ff <= nxt_ras;
         cas_ff <= nxt_cas;
         we_ff <= nxt_we;
         toe_ff <= nxt_toe;
         dout_ff <= nxt_dout;
         doe_ff <= nxt_doe;
         done_ff <= nxt_done;
         rdata_ff <= nxt_rdata;
         rdbuf_ff <= nxt_rdbuf;
         miss_ff <= nxt_miss;
         mk_ff <= nxt_mk;
         rcnt_ff <= nxt_rcnt;
         rpend_ff <= nxt_rpend;
         rbank_ff <= nxt_rbank;
         bank_ff <= nxt_bank;
         w16_ff <= nxt_w16;
         wdat_ff <= nxt_wdat;
         size_ff <= nxt_size;
         wr_ff <= nxt_wr;
         a0_ff <= nxt_a0;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign req_done = done_ff;
   assign req_rdata = rdata_ff;
   assign map_miss = miss_ff;
   assign miss_kind = mk_ff;
   assign mem_addr = addr_ff;
   assign row_strobes_n = ras_ff;
   assign column_strobes = cas_ff;
   assign write_en_n = we_ff;
   assign transfer_output_enable = toe_ff;
   assign instr_data_out = dout_ff;
   assign instr_data_oe = doe_ff;

   //////////////////////////////////////////////////////////////////////
   // checks
   sequence s_norm_start;
      st_ff == DRC_IDLE && nxt_st == DRC_NORM;
   endsequence
   property p_norm_len;
      @(posedge sys_clk) disable iff (reset)
      s_norm_start |=> (st_ff == DRC_NORM) [*3] ##1 (st_ff != DRC_NORM || cyc_ff == 3'h0);
   endproperty
   a_norm_len: assert property (p_norm_len) else $error("normal cycle length wrong"); // [R14]
   property p_ras_rise;
      @(posedge sys_clk) disable iff (reset)
      s_norm_start |=> ##2 row_strobes_n == 4'hf;
   endproperty
   a_ras_rise: assert property (p_ras_rise) else $error("row strobe not released"); // [R15]
   property p_rate_zero;
      @(posedge sys_clk) disable iff (reset)
      rate == 9'h000 |=> rpend_ff == 4'h0;
   endproperty
   a_rate_zero: assert property (p_rate_zero) else $error("refresh pending with rate 0"); // [R18]
   property p_panic;
      @(posedge sys_clk) disable iff (reset)
      panic && st_ff == DRC_IDLE |=> st_ff == DRC_REF;
   endproperty
   a_panic: assert property (p_panic) else $error("panic refresh not taken"); // [R20]
   property p_miss;
      @(posedge sys_clk) disable iff (reset)
      st_ff == DRC_IDLE && start && !ref_go && in_win && !map_hit |=> map_miss && req_done;
   endproperty
   a_miss: assert property (p_miss) else $error("mapping miss not raised"); // [R13]
   property p_win_map;
      @(posedge sys_clk) disable iff (reset)
      (s_norm_start and in_win) |=> mem_addr[23:16] == $past(map_phys);
   endproperty
   a_win_map: assert property (p_win_map) else $error("physical base not used"); // [R11]
   property p_dma;
      @(posedge sys_clk) disable iff (reset)
      (s_norm_start and req_dma) |=> mem_addr == $past(req_addr[23:1]);
   endproperty
   a_dma: assert property (p_dma) else $error("dma access remapped"); // [R10]
   property p_vid_bus;
      @(posedge sys_clk) disable iff (reset)
      st_ff == DRC_IDLE && nxt_st == DRC_VID |=> instr_data_oe [*3];
   endproperty
   a_vid_bus: assert property (p_vid_bus) else $error("video cycle floated bus"); // [R21]
endmodule

// file: core/drc_pkg.sv
// types for the dram access and refresh controller
package drc_pkg;
   typedef enum logic [2:0] {
      DRC_IDLE = 3'b000,
      DRC_NORM = 3'b001,
      DRC_PAGE = 3'b010,
      DRC_VID = 3'b011,
      DRC_REF = 3'b100
   } drc_state_t;
   typedef enum logic [1:0] {
      DRC_SZ_BYTE = 2'b00,
      DRC_SZ_HALF = 2'b01,
      DRC_SZ_WORD = 2'b10
   } drc_size_t;
endpackage

// file: test/dram_access_refresh_controller_test.sv
// self-checking bench for the dram access controller
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////
module dram_access_refresh_controller_test;
   logic sys_clk = 0, reset = 1;
   logic psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = 0, pwdata = 0, prdata;
   logic pready, pslverr;
   logic req_valid = 0, req_write = 0, req_seq = 0, req_dma = 0, req_instr = 0, req_super = 0;
   logic [31:0] req_addr = 0, req_wdata = 0, req_rdata;
   logic [1:0] req_size = 0, req_bank = 0, miss_kind;
   logic req_done, map_miss, write_en_n, transfer_output_enable, instr_data_oe;
   logic [23:1] mem_addr;
   logic [3:0] row_strobes_n, column_strobes;
   logic [31:0] instr_data_out, instr_data_in;
   int failures = 0, check_count = 0, cyc = 0, n, n32, seed, snap[4];
   logic [31:0] rd, a, wd, rdat;
   logic err, miss, saw_toe = 0;
   logic [1:0] kind;
   always #4 sys_clk = ~sys_clk;
   drc_ctrl i_dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write),
      .req_size(req_size), .req_bank(req_bank), .req_seq(req_seq), .req_dma(req_dma),
      .req_instr(req_instr), .req_super(req_super), .req_wdata(req_wdata),
      .req_done(req_done), .req_rdata(req_rdata), .map_miss(map_miss), .miss_kind(miss_kind),
      .mem_addr(mem_addr), .row_strobes_n(row_strobes_n), .column_strobes(column_strobes),
      .write_en_n(write_en_n), .transfer_output_enable(transfer_output_enable),
      .instr_data_out(instr_data_out), .instr_data_oe(instr_data_oe),
      .instr_data_in(instr_data_in));
   drc_dram_model i_mem (.sys_clk(sys_clk), .mem_addr(mem_addr), .row_strobes_n(row_strobes_n),
      .column_strobes(column_strobes), .write_en_n(write_en_n),
      .instr_data_out(instr_data_out), .instr_data_in(instr_data_in));
   always @(posedge sys_clk) begin
      cyc++;
      if (transfer_output_enable === 1'b0) saw_toe <= 1'b1;
      if (cyc == 20000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic mreq(input logic [31:0] ad, input logic w, input int s, input logic [1:0] bk);
      n = 0;
      req_addr <= ad;
      req_write <= w;
      req_size <= s[1:0];
      req_bank <= bk;
      req_wdata <= wd;
      req_valid <= 1'b1;
      do begin @(posedge sys_clk); n++; end while (req_done !== 1'b1 && n < 50);
      rdat = req_rdata;
      miss = map_miss;
      kind = miss_kind;
      req_valid <= 1'b0;
      @(posedge sys_clk);
   endtask
   function automatic logic [3:0] exp_cas(input logic w16, input int s, input int o);
      if (s == 2) return w16 ? 4'h3 : 4'h0;
      if (s == 1) return (!w16 && o[1]) ? 4'hc : 4'h3;
      return w16 ? (o[0] ? 4'hb : 4'h7) : ~(4'h8 >> o);
   endfunction
   task automatic clrq();
      i_mem.q_a.delete();
      i_mem.q_cas.delete();
      i_mem.q_d.delete();
   endtask
   task automatic refresh_gap(input int lo, input int hi);
      for (int b = 0; b < 4; b++) snap[b] = i_mem.ref_cnt[b];
      repeat (100) @(posedge sys_clk);
      for (int b = 0; b < 4; b++) begin
         chk({31'h0, (i_mem.ref_cnt[b] - snap[b]) inside {[lo:hi]}}, 32'h1);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      seed = 32'h6957;
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      apb(0, 32'h0, 0);
      chk(rd, 32'h1ff);
      apb(1, 32'h40, 32'h1234);
      chk({31'h0, err}, 32'h1);
      apb(1, 32'h0, 32'h0002_0000);
      // both widths, every size and aligned offset
      for (int w = 0; w < 2; w++) begin
         for (int s = 0; s < 3; s++) begin
            for (int o = 0; o < 4; o += (1 << s)) begin
               clrq();
               a = 32'h0001_0000 | ($random(seed) & 32'hfff0) | o;
               wd = $random(seed);
               mreq(a, 1'b1, s, w[1:0]);
               chk(i_mem.q_cas[0], exp_cas(w, s, o));
               chk(i_mem.q_a.size(), (w == 1 && s == 2) ? 2 : 1);
               if (w == 1 && s == 0) chk(i_mem.q_d[0][31:24], i_mem.q_d[0][23:16]);
               if (s == 2 && w == 0) n32 = n;
               if (w == 1 && s == 2) begin
                  chk(n - n32, 4);
                  chk(i_mem.q_cas[1], 4'h3);
                  chk(i_mem.q_a[1], i_mem.q_a[0] + 1);
                  chk(i_mem.q_d[0][31:16], wd[31:16]);
                  chk(i_mem.q_d[1][31:16], wd[15:0]);
               end
            end
         end
         a = 32'h0001_0000 | ($random(seed) & 32'hfffc);
         mreq(a, 1'b0, 2, w[1:0]);
         if (w == 0) chk(rdat, {a[16:1], ~a[16:1]});
         else chk(rdat, {a[16:1], a[16:1] + 16'h1});
      end
      // mapping entries, two matching, one invalid
      apb(1, 32'h10, 32'h8012_0003);
      apb(1, 32'h14, 32'h8012_0007);
      apb(1, 32'h18, 32'h0034_0005);
      apb(1, 32'h1c, 32'h8056_0009);
      clrq();
      mreq(32'h5012_0040, 1'b0, 2, 0);
      chk(i_mem.q_a[0][23:16], 8'h03);
      mreq(32'h5056_0000, 1'b0, 2, 0);
      chk(i_mem.q_a[1][23:16], 8'h09);
      req_dma <= 1'b1;
      mreq(32'h5012_0040, 1'b0, 2, 0);
      chk(i_mem.q_a[2][23:16], 8'h12);
      req_dma <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         req_super <= k[1];
         req_instr <= k[0];
         clrq();
         mreq(32'h5034_0000, 1'b0, 2, 0);
         chk({30'h0, miss, (i_mem.q_a.size() == 0)}, 32'h3);
         chk(kind, {k[1], ~k[0]});
      end
      // video transfer cycle
      saw_toe <= 1'b0;
      mreq(32'h6000_0100, 1'b0, 2, 0);
      chk(saw_toe, 1'b1);
      // background refresh, then under traffic, then off
      apb(1, 32'h0, 32'h0002_0028);
      repeat (10) @(posedge sys_clk);
      refresh_gap(2, 4);
      for (int b = 0; b < 4; b++) snap[b] = i_mem.ref_cnt[b];
      for (int i = 0; i < 20; i++) begin
         wd = $random(seed);
         mreq(32'h0002_0000 | (wd & 32'hfffc), wd[0], 2, wd[2:1]);
      end
      for (int b = 0; b < 4; b++) chk({31'h0, i_mem.ref_cnt[b] > snap[b]}, 32'h1);
      apb(1, 32'h0, 32'h0002_0000);
      repeat (10) @(posedge sys_clk);
      refresh_gap(0, 0);
      tally_and_finish();
   end
endmodule

// file: test/drc_dram_model.sv
// behavioural dram banks on the far side of the controller
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////
module drc_dram_model (
   // clock
   input wire logic sys_clk,
   // dram pins from the controller
   input wire logic [23:1] mem_addr,
   input wire logic [3:0] row_strobes_n,
   input wire logic [3:0] column_strobes,
   input wire logic write_en_n,
   input wire logic [31:0] instr_data_out,
   // read data back
   output logic [31:0] instr_data_in
);
   logic [3:0] cas_q = 4'hf;
   logic [3:0] ras_q = 4'hf;
   logic [31:0] last_q = 32'h0;
   logic [23:1] q_a[$];
   logic [3:0] q_cas[$];
   logic [31:0] q_d[$];
   int ref_cnt[4] = '{0, 0, 0, 0};
   wire rd_now = (column_strobes != 4'hf) && write_en_n && (row_strobes_n != 4'hf);
   // released bus shows the inverse of the last value
   assign instr_data_in = rd_now ? {mem_addr[16:1], ~mem_addr[16:1]} : ~last_q;
   always @(posedge sys_clk) begin
      if (rd_now) begin
         last_q <= instr_data_in;
      end
      // one record per column strobe fall inside a row cycle
      if (cas_q == 4'hf && column_strobes != 4'hf && row_strobes_n != 4'hf) begin
         q_a.push_back(mem_addr);
         q_cas.push_back(column_strobes);
         q_d.push_back(instr_data_out);
      end
      // column before row: refresh of that bank
      for (int b = 0; b < 4; b++) begin
         if (ras_q[b] && !row_strobes_n[b] && column_strobes != 4'hf) begin
            ref_cnt[b]++;
         end
      end
      cas_q <= column_strobes;
      ras_q <= row_strobes_n;
   end
endmodule
